// [rtl/ptc_pkg.sv]
package ptc_pkg;

  // ****************************************
  // Register map, byte addresses on the bus
  // ****************************************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_MODE = 8'h04;
  localparam logic [7:0] ADR_CMPA = 8'h08;
  localparam logic [7:0] ADR_CAPB = 8'h0c;
  localparam logic [7:0] ADR_STAT = 8'h10;
  localparam logic [7:0] ADR_CNT = 8'h14;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_RUN = 0;
  localparam int CTRL_DBF = 1;
  localparam int CTRL_OVE = 2;
  localparam int STAT_OVF = 0;
  localparam int STAT_CPFA = 1;
  localparam int STAT_CPFB = 2;

  // ****************************************
  // Reset values and limits
  // ****************************************
  localparam logic [15:0] CMPA_RST = 16'hffff;
  localparam logic [15:0] CAPB_RST = 16'hffff;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam int PRE_W = 10;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    OP_TIMER0 = 3'h0,
    OP_TIMER1 = 3'h1,
    OP_EVENT = 3'h2,
    OP_PPG = 3'h3,
    OP_TRIG = 3'h4,
    OP_WIN = 3'h5,
    OP_PULSE = 3'h6,
    OP_RSV = 3'h7
  } ptc_opmode_t;

  typedef enum logic [3:0] {
    ST_STOP = 4'h1,
    ST_WAIT = 4'h2,
    ST_RUN = 4'h4,
    ST_SECOND = 4'h8
  } ptc_state_t;

  // Mode register layout, bit 7 down to bit 0
  typedef struct packed {
    logic capture_mode_select;
    logic retrigger_stop_enable;
    logic edge_level_select;
    logic [1:0] source_clock_select;
    ptc_opmode_t operating_mode_code;
  } ptc_mode_t;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ptc_wb_req_t;

endpackage : ptc_pkg

// [rtl/ptc_timer.sv]
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module ptc_timer #(
  parameter int PRE_W = ptc_pkg::PRE_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire ptc_pkg::ptc_wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer_input_pin,
  output logic timer_irq
);

  // ****************************************
  // Declarations
  // ****************************************
  logic ack_q;
  logic [31:0] dat_q;
  logic run_q;
  logic dbf_q;
  logic ove_q;
  ptc_pkg::ptc_mode_t mode_q;
  logic [7:0] tmp_q;
  logic [15:0] cmpa_eff_q;
  logic [15:0] cmpa_buf_q;
  logic [15:0] capb_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  ptc_pkg::ptc_state_t st_q;
  ptc_pkg::ptc_state_t st_d;
  logic ovf_q;
  logic cpfa_q;
  logic cpfb_q;
  logic irq_q;
  logic irq_d;
  logic cap_a;
  logic cap_b;
  logic [PRE_W-1:0] pre_q;
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic inc;

  // Prescaler tap for the chosen source clock
  function automatic logic tick_of(input logic [1:0] sel, input logic [PRE_W-1:0] p);
    logic t;
    t = 1'b0;
    unique case (sel)
      2'h0: t = &p;
      2'h1: t = &p[5:0];
      2'h2: t = &p[1:0];
      2'h3: t = p[0];
    endcase
    return t;
  endfunction : tick_of

  // ****************************************
  // Bus decode
  // ****************************************
  wire acc = wb_req.cyc & wb_req.stb & ~ack_q;
  wire wr = acc & wb_req.we;
  wire rd = acc & ~wb_req.we;
  wire hit_ctrl = wb_req.adr == ptc_pkg::ADR_CTRL;
  wire hit_mode = wb_req.adr == ptc_pkg::ADR_MODE;
  wire hit_cmpa = wb_req.adr == ptc_pkg::ADR_CMPA;
  wire hit_capb = wb_req.adr == ptc_pkg::ADR_CAPB;
  wire hit_stat = wb_req.adr == ptc_pkg::ADR_STAT;
  wire hit_cnt = wb_req.adr == ptc_pkg::ADR_CNT;
  wire pw = mode_q.operating_mode_code == ptc_pkg::OP_PULSE;
  wire trig = mode_q.operating_mode_code == ptc_pkg::OP_TRIG;
  wire wr_ctrl = wr & hit_ctrl & wb_req.sel[0];
  wire wr_mode = wr & hit_mode & wb_req.sel[0] & ~run_q;
  wire wr_lo = wr & hit_cmpa & wb_req.sel[0] & ~pw;
  wire wr_hi = wr & hit_cmpa & wb_req.sel[1] & ~pw;
  wire rd_stat = rd & hit_stat;
  // Both lanes in one write commit the fresh low byte
  wire [7:0] lo_val = wr_lo ? wb_req.dat[7:0] : tmp_q;
  wire [15:0] wr_val = {wb_req.dat[15:8], lo_val};
  wire [15:0] cmpa_rd = dbf_q ? cmpa_buf_q : cmpa_eff_q;
  wire [31:0] rd_data =
    hit_ctrl ? {29'h0, ove_q, dbf_q, run_q} :
    hit_mode ? {24'h0, mode_q} :
    hit_cmpa ? {16'h0, cmpa_rd} :
    hit_capb ? {16'h0, capb_q} :
    hit_stat ? {29'h0, cpfb_q, cpfa_q, ovf_q} :
    hit_cnt ? {16'h0, cnt_q} : 32'h0;

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign timer_irq = irq_q;

  // Every cycle gets one ack; unmapped reads return zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= acc;
      dat_q <= rd ? rd_data : dat_q;
    end
  end

  // ****************************************
  // Control and mode registers
  // ****************************************
  // Run and buffer enable always writable; the rest lock while running
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      run_q <= 1'b0;
      dbf_q <= 1'b0;
      ove_q <= 1'b0;
      mode_q <= ptc_pkg::ptc_mode_t'(ptc_pkg::MODE_RST);
    end else begin
      run_q <= wr_ctrl ? wb_req.dat[ptc_pkg::CTRL_RUN] : run_q;
      dbf_q <= wr_ctrl ? wb_req.dat[ptc_pkg::CTRL_DBF] : dbf_q;
      ove_q <= (wr_ctrl & ~run_q) ? wb_req.dat[ptc_pkg::CTRL_OVE] : ove_q;
      mode_q <= wr_mode ? ptc_pkg::ptc_mode_t'(wb_req.dat[7:0]) : mode_q;
    end
  end

  // ****************************************
  // Pin input and prescaler
  // ****************************************
  // Two-stage synchroniser, third stage only for edge detection;
  // levels shorter than one cycle may be lost
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      pre_q <= '0;
    end else begin
      s1_q <= timer_input_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pre_q <= pre_q + 1'b1;
    end
  end

  wire rise = s2_q & ~s3_q;
  wire fall = ~s2_q & s3_q;
  wire sel_edge = mode_q.edge_level_select ? fall : rise;
  wire opp_edge = mode_q.edge_level_select ? rise : fall;
  wire level_ok = s2_q ^ mode_q.edge_level_select;
  wire tick = tick_of(mode_q.source_clock_select, pre_q);

  // Count source per mode
  always_comb begin
    unique case (mode_q.operating_mode_code)
      ptc_pkg::OP_EVENT: inc = sel_edge;
      ptc_pkg::OP_WIN: inc = tick & level_ok;
      default: inc = tick;
    endcase
  end

  // ****************************************
  // Counter and sequencer
  // ****************************************
  wire counting = (st_q == ptc_pkg::ST_RUN) | (st_q == ptc_pkg::ST_SECOND);
  wire [15:0] nxt = cnt_q + 16'h0001;
  // Value below count waits for the wrap before matching
  wire match = run_q & counting & inc & ~pw & (nxt == cmpa_eff_q);
  wire ovf_ev = run_q & counting & inc & pw & (cnt_q == ptc_pkg::CNT_MAX);
  wire start_pw = run_q & (st_q == ptc_pkg::ST_STOP) & pw;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    irq_d = 1'b0;
    cap_a = 1'b0;
    cap_b = 1'b0;
    if (!run_q) begin
      st_d = ptc_pkg::ST_STOP;
      cnt_d = 16'h0000;
    end else begin
      unique case (st_q)
        ptc_pkg::ST_STOP: begin
          cnt_d = 16'h0000;
          st_d = (trig | pw) ? ptc_pkg::ST_WAIT : ptc_pkg::ST_RUN;
        end
        // Opposite edges before a start edge are ignored
        ptc_pkg::ST_WAIT: begin
          if (sel_edge) begin
            st_d = ptc_pkg::ST_RUN;
            irq_d = pw;
          end
        end
        ptc_pkg::ST_RUN, ptc_pkg::ST_SECOND: begin
          cnt_d = inc ? nxt : cnt_q;
          if (match) begin
            cnt_d = 16'h0000;
            irq_d = 1'b1;
          end
          if (ovf_ev) begin
            irq_d = ove_q;
          end
          // In trigger mode without retrigger-stop no edge is acted on here
          if (trig & mode_q.retrigger_stop_enable & opp_edge) begin
            st_d = ptc_pkg::ST_WAIT;
            cnt_d = 16'h0000;
          end
          if (pw & (st_q == ptc_pkg::ST_RUN) & opp_edge) begin
            cap_b = 1'b1;
            irq_d = 1'b1;
            if (mode_q.capture_mode_select) begin
              st_d = ptc_pkg::ST_WAIT;
              cnt_d = 16'h0000;
            end else begin
              st_d = ptc_pkg::ST_SECOND;
            end
          end
          if (pw & (st_q == ptc_pkg::ST_SECOND) & sel_edge) begin
            cap_a = 1'b1;
            irq_d = 1'b1;
            cnt_d = 16'h0000;
            st_d = ptc_pkg::ST_RUN;
          end
        end
        default: st_d = ptc_pkg::ST_STOP;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q <= ptc_pkg::ST_STOP;
      cnt_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      irq_q <= irq_d;
    end
  end

  // ****************************************
  // Compare A, capture B
  // ****************************************
  // Captures are overwritten by the next edge, so unread values are lost
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tmp_q <= 8'hff;
      cmpa_eff_q <= ptc_pkg::CMPA_RST;
      cmpa_buf_q <= ptc_pkg::CMPA_RST;
      capb_q <= ptc_pkg::CAPB_RST;
    end else begin
      tmp_q <= wr_lo ? wb_req.dat[7:0] : tmp_q;
      if (start_pw) begin
        cmpa_eff_q <= 16'h0000;
        cmpa_buf_q <= 16'h0000;
      end else if (cap_a) begin
        cmpa_eff_q <= cnt_q;
        cmpa_buf_q <= cnt_q;
      end else if (wr_hi) begin
        cmpa_buf_q <= wr_val;
        cmpa_eff_q <= (dbf_q & run_q) ? cmpa_eff_q : wr_val;
      end else if (match & dbf_q) begin
        cmpa_eff_q <= cmpa_buf_q;
      end
      if (start_pw) begin
        capb_q <= 16'h0000;
      end else if (cap_b) begin
        capb_q <= cnt_q;
      end
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  // Set beats the read-clear; bus writes never touch them
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ovf_q <= 1'b0;
      cpfa_q <= 1'b0;
      cpfb_q <= 1'b0;
    end else begin
      ovf_q <= ovf_ev | (ovf_q & ~rd_stat);
      cpfa_q <= cap_a | (cpfa_q & ~rd_stat);
      cpfb_q <= cap_b | (cpfb_q & ~rd_stat);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  wire no_set = ~ovf_ev & ~cap_a & ~cap_b;

  property p_stop_clear;
    @(posedge clk_sys) disable iff (reset)
    $fell(run_q) |=> (cnt_q == 16'h0000) && (st_q == ptc_pkg::ST_STOP);
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("counter not cleared on stop");

  property p_mode_lock;
    @(posedge clk_sys) disable iff (reset)
    run_q && wr && (hit_mode || hit_ctrl) |=> $stable(mode_q) && $stable(ove_q);
  endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("mode changed while running");

  property p_dbf_hold;
    @(posedge clk_sys) disable iff (reset)
    run_q && dbf_q && wr_hi |=> (cmpa_buf_q == $past(wr_val)) && $stable(cmpa_eff_q);
  endproperty
  a_dbf_hold: assert property (p_dbf_hold) else $error("buffered write reached compare");

  property p_direct;
    @(posedge clk_sys) disable iff (reset)
    (!dbf_q || !run_q) && wr_hi |=> cmpa_eff_q == $past(wr_val);
  endproperty
  a_direct: assert property (p_direct) else $error("direct compare write lost");

  property p_read_buf;
    @(posedge clk_sys) disable iff (reset)
    rd && hit_cmpa && dbf_q |=> wb_ack_o && (wb_dat_o[15:0] == $past(cmpa_buf_q));
  endproperty
  a_read_buf: assert property (p_read_buf) else $error("compare read not buffered");

  property p_match;
    @(posedge clk_sys) disable iff (reset)
    match |=> timer_irq && (cnt_q == 16'h0000);
  endproperty
  a_match: assert property (p_match) else $error("match did not clear");

  property p_pw_capb;
    @(posedge clk_sys) disable iff (reset)
    run_q && pw && (st_q == ptc_pkg::ST_RUN) && opp_edge |=> (capb_q == $past(cnt_q)) && cpfb_q && timer_irq;
  endproperty
  a_pw_capb: assert property (p_pw_capb) else $error("capture B missed");

  property p_pw_start;
    @(posedge clk_sys) disable iff (reset)
    start_pw |=> (cmpa_eff_q == 16'h0000) && (capb_q == 16'h0000) && (st_q == ptc_pkg::ST_WAIT);
  endproperty
  a_pw_start: assert property (p_pw_start) else $error("pulse start not zeroed");

  property p_stat_clr;
    @(posedge clk_sys) disable iff (reset)
    rd_stat && no_set |=> !ovf_q && !cpfa_q && !cpfb_q;
  endproperty
  a_stat_clr: assert property (p_stat_clr) else $error("status read did not clear");

  property p_stat_wr;
    @(posedge clk_sys) disable iff (reset)
    wr && hit_stat && no_set |=> $stable({ovf_q, cpfa_q, cpfb_q});
  endproperty
  a_stat_wr: assert property (p_stat_wr) else $error("status write changed flags");

  property p_ovf;
    @(posedge clk_sys) disable iff (reset)
    ovf_ev && !opp_edge && !sel_edge |=> ovf_q && (timer_irq == $past(ove_q));
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow handling wrong");

  c_match: cover property (@(posedge clk_sys) disable iff (reset) match && dbf_q);
  c_cap_a: cover property (@(posedge clk_sys) disable iff (reset) cap_a);
  c_ovf: cover property (@(posedge clk_sys) disable iff (reset) ovf_ev && ove_q);
  c_retrig: cover property (@(posedge clk_sys) disable iff (reset) counting && trig && opp_edge);

endmodule : ptc_timer

// [testbench/ptc_pin_src.sv]
`timescale 1ns/100ps
// ****************************************
// Slow event source on the timer pin
// ****************************************
module ptc_pin_src (
  input wire logic clk_sys,
  input wire logic want,
  output logic pin
);
  logic [1:0] held_q = 2'h0;
  logic pin_q = 1'b0;

  // Follow the requested level, but never sooner than three cycles after the last change
  always_ff @(posedge clk_sys) begin
    if (held_q != 2'h2) begin
      held_q <= held_q + 2'h1;
    end else if (want != pin_q) begin
      pin_q <= want;
      held_q <= 2'h0;
    end
  end

  assign pin = pin_q;
endmodule : ptc_pin_src

// [testbench/testbench.sv]
`timescale 1ns/100ps
module testbench;
  // ****************************************
  // Clock, reset and instances
  // ****************************************
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic want = 1'b0;
  logic pin;
  ptc_pkg::ptc_wb_req_t wb_req = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic timer_irq;
  int failures = 0;
  int total_checks = 0;
  int irqs = 0;
  int i0;
  int n;
  logic [31:0] v;
  logic [31:0] a;
  logic [15:0] rv;
  logic esel;

  always #12.5 clk_sys = ~clk_sys;

  ptc_timer i_ptc_timer (.clk_sys(clk_sys), .reset(reset), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timer_input_pin(pin), .timer_irq(timer_irq));
  ptc_pin_src i_ptc_pin_src (.clk_sys(clk_sys), .want(want), .pin(pin));

  // Count interrupt pulses away from the launching edge
  always @(negedge clk_sys) if (timer_irq === 1'b1) irqs++;

  // ****************************************
  // Tasks and expectation helpers
  // ****************************************
  task automatic print_verdict();
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle, held until the slave's ack; read data taken at that edge
  task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    @(posedge clk_sys);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    v = wb_dat_o;
    wb_req <= '0;
  endtask : bus

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    bus(1'b1, adr, 4'h1, {24'h0, dat});
  endtask : wr

  // Low byte first, then the high byte commits both
  task automatic wr_cmpa(input logic [15:0] val);
    bus(1'b1, ptc_pkg::ADR_CMPA, 4'h1, {16'h0, val});
    bus(1'b1, ptc_pkg::ADR_CMPA, 4'h2, {16'h0, val});
  endtask : wr_cmpa

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 4'hf, 32'h0);
    chk(v, exp);
  endtask : rd

  // Room for the source's hold, the two-flop sync and the edge detect
  task automatic pin_to(input logic lvl);
    @(posedge clk_sys);
    want <= lvl;
    repeat (10) @(posedge clk_sys);
  endtask : pin_to

  task automatic pulse(input int k);
    repeat (k) begin
      pin_to(~esel);
      pin_to(esel);
    end
  endtask : pulse

  // Mode byte with the fastest prescaler, so timed modes move quickly
  function automatic logic [7:0] mode_of(input logic mcap, input logic rse, input logic es, input logic [2:0] m);
    return {mcap, rse, es, 2'h3, m};
  endfunction : mode_of

  // Hang guard, far beyond the roughly 1,200 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    print_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(59318));
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rd(ptc_pkg::ADR_CTRL, 32'h0);
    rd(ptc_pkg::ADR_MODE, {24'h0, ptc_pkg::MODE_RST});
    rd(ptc_pkg::ADR_CMPA, {16'h0, ptc_pkg::CMPA_RST});
    rd(ptc_pkg::ADR_CAPB, {16'h0, ptc_pkg::CAPB_RST});
    rd(ptc_pkg::ADR_STAT, 32'h0);
    rd(8'h20, 32'h0);
    // Stopped writes, and a lone low byte that must wait for its high byte
    rv = 16'($urandom);
    wr_cmpa(rv);
    rd(ptc_pkg::ADR_CMPA, {16'h0, rv});
    bus(1'b1, ptc_pkg::ADR_CMPA, 4'h1, 32'h5a);
    rd(ptc_pkg::ADR_CMPA, {16'h0, rv});
    bus(1'b1, ptc_pkg::ADR_CMPA, 4'h2, 32'h0);
    rd(ptc_pkg::ADR_CMPA, 32'h5a);
    // Event counting with a random edge and compare value
    n = 5 + int'($urandom % 4);
    esel = 1'($urandom);
    wr(ptc_pkg::ADR_MODE, mode_of(1'b0, 1'b0, esel, ptc_pkg::OP_EVENT));
    pin_to(esel);
    wr_cmpa(16'(n));
    wr(ptc_pkg::ADR_CTRL, 8'h01);
    wr(ptc_pkg::ADR_MODE, 8'h00);
    rd(ptc_pkg::ADR_MODE, {24'h0, mode_of(1'b0, 1'b0, esel, ptc_pkg::OP_EVENT)});
    wr(ptc_pkg::ADR_CTRL, 8'h05);
    rd(ptc_pkg::ADR_CTRL, 32'h1);
    i0 = irqs;
    pulse(n - 1);
    rd(ptc_pkg::ADR_CNT, 32'(n - 1));
    chk(irqs - i0, 0);
    pulse(1);
    rd(ptc_pkg::ADR_CNT, 32'h0);
    chk(irqs - i0, 1);
    // Unbuffered write below the count: no match until the wrap
    pulse(3);
    wr_cmpa(16'h2);
    pulse(1);
    rd(ptc_pkg::ADR_CNT, 32'h4);
    chk(irqs - i0, 1);
    wr(ptc_pkg::ADR_CTRL, 8'h00);
    rd(ptc_pkg::ADR_CNT, 32'h0);
    // Buffered write while running loads at the next match
    wr(ptc_pkg::ADR_CTRL, 8'h02);
    wr_cmpa(16'h4);
    wr(ptc_pkg::ADR_CTRL, 8'h03);
    wr_cmpa(16'h2);
    rd(ptc_pkg::ADR_CMPA, 32'h2);
    i0 = irqs;
    pulse(3);
    chk(irqs - i0, 0);
    pulse(1);
    chk(irqs - i0, 1);
    pulse(2);
    chk(irqs - i0, 2);
    wr(ptc_pkg::ADR_CTRL, 8'h00);
    wr_cmpa(16'hffff);
    // Trigger without and with retrigger stop, then window counting
    for (int k = 0; k < 3; k++) begin
      wr(ptc_pkg::ADR_MODE, mode_of(1'b0, k == 1, 1'b0, (k == 2) ? ptc_pkg::OP_WIN : ptc_pkg::OP_TRIG));
      pin_to(1'b0);
      wr(ptc_pkg::ADR_CTRL, 8'h01);
      repeat (20) @(posedge clk_sys);
      rd(ptc_pkg::ADR_CNT, 32'h0);
      pin_to(1'b1);
      bus(1'b0, ptc_pkg::ADR_CNT, 4'hf, 32'h0);
      chk(v > 0 && v < 32, 1'b1);
      pin_to(1'b0);
      bus(1'b0, ptc_pkg::ADR_CNT, 4'hf, 32'h0);
      a = v;
      repeat (20) @(posedge clk_sys);
      bus(1'b0, ptc_pkg::ADR_CNT, 4'hf, 32'h0);
      if (k == 0) chk(v > a, 1'b1);
      else if (k == 1) chk(a | v, 32'h0);
      else chk(v == a && a != 0, 1'b1);
      wr(ptc_pkg::ADR_CTRL, 8'h00);
    end
    // Plain timer on the divide-by-four source, five ticks a period
    wr(ptc_pkg::ADR_MODE, 8'h10);
    wr_cmpa(16'h5);
    i0 = irqs;
    wr(ptc_pkg::ADR_CTRL, 8'h01);
    repeat (200) @(posedge clk_sys);
    wr(ptc_pkg::ADR_CTRL, 8'h00);
    chk(irqs - i0 >= 9 && irqs - i0 <= 11, 1'b1);
    rd(ptc_pkg::ADR_CNT, 32'h0);
    // Pulse width, double edge
    wr(ptc_pkg::ADR_MODE, mode_of(1'b0, 1'b0, 1'b0, ptc_pkg::OP_PULSE));
    wr(ptc_pkg::ADR_CTRL, 8'h01);
    rd(ptc_pkg::ADR_CMPA, 32'h0);
    rd(ptc_pkg::ADR_CAPB, 32'h0);
    i0 = irqs;
    pin_to(1'b1);
    chk(irqs - i0, 1);
    repeat (40) @(posedge clk_sys);
    pin_to(1'b0);
    chk(irqs - i0, 2);
    wr(ptc_pkg::ADR_STAT, 8'hff);
    rd(ptc_pkg::ADR_STAT, 32'h4);
    rd(ptc_pkg::ADR_STAT, 32'h0);
    bus(1'b0, ptc_pkg::ADR_CAPB, 4'hf, 32'h0);
    a = v;
    chk(v > 15 && v < 40, 1'b1);
    pin_to(1'b1);
    chk(irqs - i0, 3);
    rd(ptc_pkg::ADR_STAT, 32'h2);
    bus(1'b0, ptc_pkg::ADR_CMPA, 4'hf, 32'h0);
    chk(v > a, 1'b1);
    bus(1'b0, ptc_pkg::ADR_CNT, 4'hf, 32'h0);
    chk(v < 16, 1'b1);
    // Pulse width, single edge: opposite edge stops and clears
    wr(ptc_pkg::ADR_CTRL, 8'h00);
    pin_to(1'b0);
    wr(ptc_pkg::ADR_MODE, mode_of(1'b1, 1'b0, 1'b0, ptc_pkg::OP_PULSE));
    wr(ptc_pkg::ADR_CTRL, 8'h01);
    pin_to(1'b1);
    repeat (20) @(posedge clk_sys);
    pin_to(1'b0);
    repeat (20) @(posedge clk_sys);
    rd(ptc_pkg::ADR_CNT, 32'h0);
    wr(ptc_pkg::ADR_CTRL, 8'h00);
    print_verdict();
  end
endmodule : testbench
